// [core/gps_pkg.sv]
// Purpose: shared constants and types for the port-A pin block with steering
// Assumes: AXI4-Lite register access, 32-bit data, registers in the low byte
// Notes: offsets are byte addresses of aligned words
package gps_pkg;

    localparam int GPS_PINS = 6;
    localparam int GPS_REG_W = 8;
    localparam int GPS_ADDR_W = 8;

    // register byte offsets
    localparam logic [GPS_ADDR_W-1:0] OFS_PIN_DATA = 8'h00;
    localparam logic [GPS_ADDR_W-1:0] OFS_LATCH = 8'h04;
    localparam logic [GPS_ADDR_W-1:0] OFS_DIRECTION = 8'h08;
    localparam logic [GPS_ADDR_W-1:0] OFS_ANALOG = 8'h0C;
    localparam logic [GPS_ADDR_W-1:0] OFS_STEERING = 8'h10;
    localparam logic [GPS_ADDR_W-1:0] OFS_BIT_MODIFY = 8'h14;

    // implemented-bit masks and fixed bits
    localparam logic [GPS_REG_W-1:0] PIN_DATA_MASK = 8'h3F;
    localparam logic [GPS_REG_W-1:0] LATCH_MASK = 8'h37;
    localparam logic [GPS_REG_W-1:0] DIR_MASK = 8'h37;
    localparam logic [GPS_REG_W-1:0] DIR_FIXED_ONES = 8'h08;
    localparam logic [GPS_REG_W-1:0] ANALOG_MASK = 8'h17;
    localparam logic [GPS_REG_W-1:0] STEER_MASK = 8'h3B;

    // reset values
    localparam logic [GPS_REG_W-1:0] LATCH_RESET = 8'h00;
    localparam logic [GPS_REG_W-1:0] DIR_RESET = 8'h3F;
    localparam logic [GPS_REG_W-1:0] ANALOG_RESET = 8'h17;
    localparam logic [GPS_REG_W-1:0] STEER_RESET = 8'h00;

    // steering bit positions
    localparam int STEER_SERIAL_OUT = 5;
    localparam int STEER_SLAVE_SEL = 4;
    localparam int STEER_TIMER_GATE = 3;
    localparam int STEER_LOGIC_CELL = 1;
    localparam int STEER_OSC_OUT = 0;

    // port A pin indices
    localparam int PIN_A2 = 2;
    localparam int PIN_A3 = 3;
    localparam int PIN_A4 = 4;

    // bit-modify word layout: value in [7:0], mask in [15:8]
    localparam int MOD_VAL_LSB = 0;
    localparam int MOD_MASK_LSB = 8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        SEL_NONE,
        SEL_PIN_DATA,
        SEL_LATCH,
        SEL_DIRECTION,
        SEL_ANALOG,
        SEL_STEERING,
        SEL_BIT_MODIFY
    } gps_sel_t;

    // a peripheral output asking for a pin: enable and level
    typedef struct packed {
        logic en;
        logic val;
    } gps_drive_t;

    // override bundle handed to the port C pin logic
    typedef struct packed {
        gps_drive_t pin_c5;
        gps_drive_t pin_c2;
        gps_drive_t pin_c1;
    } gps_port_c_ovr_t;

    // port A pad bundle; oe_n low while the block drives the pad
    typedef struct packed {
        logic [GPS_PINS-1:0] out;
        logic [GPS_PINS-1:0] oe_n;
    } gps_pad_out_t;

endpackage

// [core/gps_port.sv]
// Purpose: six-pin port A with direction, latch, analog select and pin steering
// Assumes: pad inputs asynchronous to core_clk; AXI4-Lite register slave
// Notes: port C pins only receive overrides and one input from this block
// Notes on behaviour
// RULE_01: latch write acts like pin data write
// RULE_02: latch read stored; pin read live levels
// RULE_03: enabled peripheral takes driver; pin still readable
// RULE_04: analog select kills digital input buffer
// RULE_05: steering leaves direction; overrides follow selection
// RULE_06: unselected pin sees no override
// RULE_07: bit 5 serial out A4 else C2
// RULE_08: bit 4 slave select A3 else C3
// RULE_09: bit 3 timer gate A3 else A4
// RULE_10: bit 1 logic cell C5 else A2
// RULE_11: bit 0 oscillator A4 else C1
// RULE_12: steering bits 7,6,2 read zero
// RULE_13: six bidirectional pins, own bits each; here A3 is input only
// RULE_14: direction one input, zero drives latch
// RULE_15: pin A3 input only, direction reads one
// RULE_16: pin data write is read-modify-write
// RULE_17: direction controls drivers even when analog
// RULE_18: software keeps analog pins as inputs
// RULE_19: analog pins read zero on pin data
// RULE_20: analog select leaves digital outputs alone
// RULE_21: analog select resets to analog mode
// RULE_22: pin inputs synchronised before use
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps

module gps_port
    import gps_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    // AXI4-Lite slave
    input wire logic [GPS_ADDR_W-1:0] s_axil_awaddr,
    input wire logic s_axil_awvalid,
    output logic s_axil_awready,
    input wire logic [31:0] s_axil_wdata,
    input wire logic [3:0] s_axil_wstrb,
    input wire logic s_axil_wvalid,
    output logic s_axil_wready,
    output logic [1:0] s_axil_bresp,
    output logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic [GPS_ADDR_W-1:0] s_axil_araddr,
    input wire logic s_axil_arvalid,
    output logic s_axil_arready,
    output logic [31:0] s_axil_rdata,
    output logic [1:0] s_axil_rresp,
    output logic s_axil_rvalid,
    input wire logic s_axil_rready,
    // port A pads
    input wire logic [GPS_PINS-1:0] port_a_pin_in,
    output gps_pad_out_t port_a_pad,
    // port C pin C3 level, used for slave select
    input wire logic pin_c3_in,
    // peripheral outputs asking for pins
    input wire gps_drive_t serial_out_drive,
    input wire gps_drive_t numeric_osc_output,
    input wire gps_drive_t logic_cell_one_output,
    // digital inputs delivered to peripherals
    output logic slave_select_in,
    output logic timer_one_gate_input,
    // overrides for the port C pin logic
    output gps_port_c_ovr_t port_c_ovr
);

    logic [GPS_REG_W-1:0] port_a_latch_r;
    logic [GPS_REG_W-1:0] port_a_direction_r;
    logic [GPS_REG_W-1:0] port_a_analog_select_r;
    logic [GPS_REG_W-1:0] alternate_pin_steering_r;

    logic [GPS_PINS-1:0] pin_meta_r;
    logic [GPS_PINS-1:0] pin_sync_r;
    logic c3_meta_r;
    logic c3_sync_r;

    logic aw_got_r;
    logic w_got_r;
    logic [GPS_ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] rdata_r;
    logic slave_select_r;
    logic timer_gate_r;

    logic [GPS_REG_W-1:0] pin_read;
    logic [GPS_PINS-1:0] ovr_en;
    logic [GPS_PINS-1:0] ovr_val;
    logic write_go;
    gps_sel_t wr_sel;
    gps_sel_t rd_sel;
    logic [GPS_REG_W-1:0] wr_byte;

    logic serial_out_on_a4;
    logic slave_sel_on_a3;
    logic timer_gate_on_a3;
    logic logic_cell_on_c5;
    logic osc_on_a4;
    gps_drive_t cell_a2_drv;
    gps_drive_t osc_a4_drv;
    gps_drive_t serial_a4_drv;
    logic reg_write;

    function automatic gps_sel_t decode_reg(input logic [GPS_ADDR_W-1:0] addr);
        if (addr == OFS_PIN_DATA) begin
            return SEL_PIN_DATA;
        end else if (addr == OFS_LATCH) begin
            return SEL_LATCH;
        end else if (addr == OFS_DIRECTION) begin
            return SEL_DIRECTION;
        end else if (addr == OFS_ANALOG) begin
            return SEL_ANALOG;
        end else if (addr == OFS_STEERING) begin
            return SEL_STEERING;
        end else if (addr == OFS_BIT_MODIFY) begin
            return SEL_BIT_MODIFY;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // pin levels merged into the written bits, then kept to implemented latch bits
    function automatic logic [GPS_REG_W-1:0] merge_pins(
        input logic [GPS_REG_W-1:0] pins,
        input logic [GPS_REG_W-1:0] val,
        input logic [GPS_REG_W-1:0] mask
    );
        return ((pins & ~mask) | (val & mask)) & LATCH_MASK;
    endfunction

    // a steered function reaches only its selected pin; the other sees a quiet bundle
    function automatic gps_drive_t gate_drive(
        input logic chosen,
        input gps_drive_t drive
    );
        gps_drive_t gated;
        gated.en = chosen && drive.en;
        gated.val = chosen && drive.val;
        return gated;
    endfunction

    // two-stage synchronisers; only stage two is looked at
    // stages reset low, so every pin reads zero for two edges after reset
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pin_meta_r <= '0;
            pin_sync_r <= '0;
            c3_meta_r <= 1'b0;
            c3_sync_r <= 1'b0;
        end else begin
            pin_meta_r <= port_a_pin_in; // RULE_22
            pin_sync_r <= pin_meta_r; // RULE_22
            c3_meta_r <= pin_c3_in;
            c3_sync_r <= c3_meta_r;
        end
    end

    // analog pins have no digital input, so they read zero
    // hazard: a driven pin with analog select set reads zero, so a bit-modify
    // write copies zero into its latch bit; keep analog pins as inputs
    assign pin_read = {{(GPS_REG_W-GPS_PINS){1'b0}}, pin_sync_r}
        & ~port_a_analog_select_r; // RULE_04 RULE_19

    // steering selections
    assign serial_out_on_a4 = alternate_pin_steering_r[STEER_SERIAL_OUT]; // RULE_07
    assign slave_sel_on_a3 = alternate_pin_steering_r[STEER_SLAVE_SEL]; // RULE_08
    assign timer_gate_on_a3 = alternate_pin_steering_r[STEER_TIMER_GATE]; // RULE_09
    assign logic_cell_on_c5 = alternate_pin_steering_r[STEER_LOGIC_CELL]; // RULE_10
    assign osc_on_a4 = alternate_pin_steering_r[STEER_OSC_OUT]; // RULE_11

    // peripheral claims per port A pin; oscillator outranks serial out on A4
    assign cell_a2_drv = gate_drive(!logic_cell_on_c5, logic_cell_one_output); // RULE_10
    assign osc_a4_drv = gate_drive(osc_on_a4, numeric_osc_output); // RULE_11 RULE_05
    assign serial_a4_drv = gate_drive(serial_out_on_a4, serial_out_drive); // RULE_07 RULE_05

    always_comb begin
        ovr_en = '0;
        ovr_val = '0;
        if (cell_a2_drv.en) begin // RULE_06
            ovr_en[PIN_A2] = 1'b1;
            ovr_val[PIN_A2] = cell_a2_drv.val;
        end
        if (osc_a4_drv.en) begin // RULE_05
            ovr_en[PIN_A4] = 1'b1;
            ovr_val[PIN_A4] = osc_a4_drv.val;
        end else if (serial_a4_drv.en) begin // RULE_05
            ovr_en[PIN_A4] = 1'b1;
            ovr_val[PIN_A4] = serial_a4_drv.val;
        end
    end

    // overrides steered to port C only when that pin is the selected one
    always_comb begin
        port_c_ovr.pin_c1 = gate_drive(!osc_on_a4, numeric_osc_output); // RULE_06
        port_c_ovr.pin_c2 = gate_drive(!serial_out_on_a4, serial_out_drive); // RULE_06
        port_c_ovr.pin_c5 = gate_drive(logic_cell_on_c5, logic_cell_one_output); // RULE_06
    end

    // pad drivers: analog select plays no part in the driver path
    genvar gi;
    generate
        for (gi = 0; gi < GPS_PINS; gi++) begin : g_pad
            if (gi == PIN_A3) begin : g_in_only
                assign port_a_pad.oe_n[gi] = 1'b1; // RULE_15
                assign port_a_pad.out[gi] = 1'b0;
            end else begin : g_bidir
                // direction bit still governs analog pins
                assign port_a_pad.oe_n[gi] = port_a_direction_r[gi] & ~ovr_en[gi]; // RULE_14 RULE_03 RULE_17 RULE_20 RULE_13
                assign port_a_pad.out[gi] = ovr_en[gi] ? ovr_val[gi] : port_a_latch_r[gi]; // RULE_14 RULE_03
            end
        end
    endgenerate

    // peripheral inputs come from synchronised, analog-gated levels, registered
    // slave select from pin C3 is not analog-gated; port C analog state lives elsewhere
    always_ff @(posedge core_clk) begin
        if (srst) begin
            slave_select_r <= 1'b0;
            timer_gate_r <= 1'b0;
        end else begin
            slave_select_r <= slave_sel_on_a3 ? pin_read[PIN_A3] : c3_sync_r; // RULE_08
            timer_gate_r <= timer_gate_on_a3 ? pin_read[PIN_A3] : pin_read[PIN_A4]; // RULE_09 RULE_04
        end
    end
    assign slave_select_in = slave_select_r;
    assign timer_one_gate_input = timer_gate_r;

    // write channel: address and data taken in either order, committed together
    assign s_axil_awready = !aw_got_r && !bvalid_r;
    assign s_axil_wready = !w_got_r && !bvalid_r;
    assign write_go = aw_got_r && w_got_r && !bvalid_r;
    assign wr_sel = decode_reg(awaddr_r);
    assign wr_byte = wstrb_r[0] ? wdata_r[GPS_REG_W-1:0] : '0;
    // byte lane 0 must be strobed for any register write; lane 1 carries the bit-modify mask, lanes 2 and 3 are ignored
    assign reg_write = write_go && wstrb_r[0];
    // a response must be taken before the next address or data is accepted

    always_ff @(posedge core_clk) begin
        if (srst) begin
            aw_got_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axil_awvalid && s_axil_awready) begin
            aw_got_r <= 1'b1;
            awaddr_r <= s_axil_awaddr;
        end else if (write_go) begin
            aw_got_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            w_got_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axil_wvalid && s_axil_wready) begin
            w_got_r <= 1'b1;
            wdata_r <= s_axil_wdata;
            wstrb_r <= s_axil_wstrb;
        end else if (write_go) begin
            w_got_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
        end else if (write_go) begin
            // bresp stays put after the handshake until the next write commits
            bvalid_r <= 1'b1;
            bresp_r <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axil_bready) begin
            bvalid_r <= 1'b0;
        end
    end
    assign s_axil_bvalid = bvalid_r;
    assign s_axil_bresp = bresp_r;

    // output latch; both data paths share one merge so they act alike
    always_ff @(posedge core_clk) begin
        if (srst) begin
            port_a_latch_r <= LATCH_RESET;
        end else if (reg_write) begin
            if (wr_sel == SEL_PIN_DATA || wr_sel == SEL_LATCH) begin
                // full-byte write: every bit is replaced
                port_a_latch_r <= merge_pins(pin_read, wr_byte, PIN_DATA_MASK); // RULE_01 RULE_16
            end else if (wr_sel == SEL_BIT_MODIFY) begin
                // partial write keeps live pin levels in unmasked bits
                port_a_latch_r <= merge_pins(pin_read,
                    wdata_r[MOD_VAL_LSB +: GPS_REG_W],
                    wstrb_r[1] ? wdata_r[MOD_MASK_LSB +: GPS_REG_W] : '0); // RULE_16
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            port_a_direction_r <= DIR_RESET;
        end else if (reg_write && wr_sel == SEL_DIRECTION) begin
            port_a_direction_r <= (wr_byte & DIR_MASK) | DIR_FIXED_ONES; // RULE_15 RULE_14
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            port_a_analog_select_r <= ANALOG_RESET; // RULE_21
        end else if (reg_write && wr_sel == SEL_ANALOG) begin
            port_a_analog_select_r <= wr_byte & ANALOG_MASK;
        end
    end

    // steering touches no direction bit
    always_ff @(posedge core_clk) begin
        if (srst) begin
            alternate_pin_steering_r <= STEER_RESET;
        end else if (reg_write && wr_sel == SEL_STEERING) begin
            alternate_pin_steering_r <= wr_byte & STEER_MASK; // RULE_12 RULE_05
        end
    end

    // read channel: one cycle from address to data
    // a new address waits until the previous read data has been taken
    assign rd_sel = decode_reg(s_axil_araddr);
    assign s_axil_arready = !rvalid_r;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
        end else if (s_axil_arvalid && s_axil_arready) begin
            rvalid_r <= 1'b1;
            rresp_r <= RESP_OKAY;
            rdata_r <= '0;
            case (rd_sel)
                SEL_PIN_DATA: begin
                    rdata_r[GPS_REG_W-1:0] <= pin_read; // RULE_02 RULE_03
                end
                SEL_LATCH: begin
                    rdata_r[GPS_REG_W-1:0] <= port_a_latch_r; // RULE_02
                end
                SEL_DIRECTION: begin
                    rdata_r[GPS_REG_W-1:0] <= port_a_direction_r; // RULE_15
                end
                SEL_ANALOG: begin
                    rdata_r[GPS_REG_W-1:0] <= port_a_analog_select_r;
                end
                SEL_STEERING: begin
                    rdata_r[GPS_REG_W-1:0] <= alternate_pin_steering_r; // RULE_12
                end
                SEL_BIT_MODIFY: begin
                    rdata_r <= '0;
                end
                default: begin
                    rresp_r <= RESP_SLVERR;
                end
            endcase
        end else if (s_axil_rready) begin
            rvalid_r <= 1'b0;
        end
    end
    assign s_axil_rvalid = rvalid_r;
    assign s_axil_rresp = rresp_r;
    assign s_axil_rdata = rdata_r;

endmodule

// [tb/gps_pin_model.sv]
// Purpose: pad-side model of the six port A pins
// Assumes: no pull resistors; a released pin shows what the outside world drives
// Notes: the bench sets the outside levels per pin
`timescale 1ns/1ps

module gps_pin_model
    import gps_pkg::*;
(
    input wire gps_pad_out_t pad,
    input wire logic [GPS_PINS-1:0] ext_lvl,
    output logic [GPS_PINS-1:0] pin_lvl
);
    // a driven pad wins over the outside source, so reads show the driven level
    always_comb begin
        for (int i = 0; i < GPS_PINS; i++) begin
            pin_lvl[i] = pad.oe_n[i] ? ext_lvl[i] : pad.out[i];
        end
    end
endmodule

// [tb/gps_port_chk.sv]
// Purpose: port and bus assertions for gps_port
// Assumes: one clock, srst synchronous active high
// Notes: registers are not visible here, so checks tie pads to peripheral requests
`timescale 1ns/1ps

module gps_port_chk
    import gps_pkg::*;
(
    input wire logic core_clk,
    input wire logic srst,
    input wire logic s_axil_awvalid,
    input wire logic s_axil_awready,
    input wire logic s_axil_wvalid,
    input wire logic s_axil_wready,
    input wire logic [1:0] s_axil_bresp,
    input wire logic s_axil_bvalid,
    input wire logic s_axil_bready,
    input wire logic s_axil_arvalid,
    input wire logic s_axil_arready,
    input wire logic [31:0] s_axil_rdata,
    input wire logic s_axil_rvalid,
    input wire logic s_axil_rready,
    input wire gps_pad_out_t port_a_pad,
    input wire gps_drive_t serial_out_drive,
    input wire gps_drive_t numeric_osc_output,
    input wire gps_drive_t logic_cell_one_output,
    input wire gps_port_c_ovr_t port_c_ovr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);

    sequence s_wr_take;
        s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready;
    endsequence
    sequence s_wr_answer;
        ##[1:2] s_axil_bvalid;
    endsequence

    chk_a3_never_driven: assert property (port_a_pad.oe_n[3])
        else $error("pin a3 driven");
    chk_osc_on_a4: assert property (numeric_osc_output.en && !port_c_ovr.pin_c1.en
        |-> !port_a_pad.oe_n[4] && port_a_pad.out[4] == numeric_osc_output.val)
        else $error("oscillator not on a4");
    chk_cell_on_a2: assert property (logic_cell_one_output.en && !port_c_ovr.pin_c5.en
        |-> !port_a_pad.oe_n[2] && port_a_pad.out[2] == logic_cell_one_output.val)
        else $error("logic cell not on a2");
    chk_serial_on_a4: assert property (serial_out_drive.en
        && !(numeric_osc_output.en && !port_c_ovr.pin_c1.en)
        && !port_c_ovr.pin_c2.en |-> !port_a_pad.oe_n[4]
        && port_a_pad.out[4] == serial_out_drive.val)
        else $error("serial out not on a4");
    chk_c1_needs_osc: assert property (port_c_ovr.pin_c1.en
        |-> numeric_osc_output.en && port_c_ovr.pin_c1.val == numeric_osc_output.val)
        else $error("stray override on c1");
    chk_c2_needs_serial: assert property (port_c_ovr.pin_c2.en
        |-> serial_out_drive.en && port_c_ovr.pin_c2.val == serial_out_drive.val)
        else $error("stray override on c2");
    chk_write_answer: assert property (s_wr_take |-> s_wr_answer)
        else $error("write response late");
    chk_read_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
        else $error("read response late");
    chk_rdata_holds: assert property (s_axil_rvalid && !s_axil_rready
        |=> s_axil_rvalid && $stable(s_axil_rdata))
        else $error("read data dropped");
    chk_bresp_holds: assert property (s_axil_bvalid && !s_axil_bready
        |=> s_axil_bvalid && $stable(s_axil_bresp))
        else $error("write response dropped");
endmodule

// [tb/gps_port_tb_top.sv]
// Purpose: register-level tests of gps_port over AXI4-Lite
// Assumes: pin reads lag pads by 2 edges, peripheral inputs by 3
// Notes: waits of 5 cycles cover the synchronisers
`timescale 1ns/1ps

module gps_port_tb_top
    import gps_pkg::*;
;
    logic core_clk = 1'b0, srst = 1'b1, pin_c3_in = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, ss_in, tg_in;
    logic [1:0] bresp, rresp;
    logic [5:0] ext_lvl = 6'h3F, pin_lvl;
    gps_pad_out_t pad;
    gps_port_c_ovr_t c_ovr;
    gps_drive_t so_d = 2'b00, osc_d = 2'b00, lc_d = 2'b00;
    int n_fail = 0, n_tests = 0, n_cyc = 0;
    logic [7:0] st_v [3] = '{8'h00, 8'h3B, 8'h20};
    logic [7:0] st_pin [3] = '{8'h04, 8'h10, 8'h14};
    logic [5:0] st_oe [3] = '{6'h3B, 6'h2F, 6'h2B};
    logic [5:0] st_ovr [3] = '{6'h0F, 6'h30, 6'h03};
    logic [1:0] st_in [3] = '{2'b01, 2'b00, 2'b11};

    gps_port i_gps_port (.core_clk(core_clk), .srst(srst), .s_axil_awaddr(awaddr),
        .s_axil_awvalid(awvalid), .s_axil_awready(awready), .s_axil_wdata(wdata),
        .s_axil_wstrb(4'hF), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
        .s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
        .s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
        .s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid),
        .s_axil_rready(rready), .port_a_pin_in(pin_lvl), .port_a_pad(pad),
        .pin_c3_in(pin_c3_in), .serial_out_drive(so_d), .numeric_osc_output(osc_d),
        .logic_cell_one_output(lc_d), .slave_select_in(ss_in),
        .timer_one_gate_input(tg_in), .port_c_ovr(c_ovr));
    gps_pin_model i_gps_pin_model (.pad(pad), .ext_lvl(ext_lvl), .pin_lvl(pin_lvl));

    always #10 core_clk = ~core_clk;

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge core_clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        #1;
        while (awvalid || wvalid) begin
            @(posedge core_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            #1;
        end
        do @(posedge core_clk); while (!bvalid);
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (!arready);
        arvalid <= 1'b0;
        while (!rvalid) @(posedge core_clk);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, {24'h0, e});
    endtask

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge core_clk);
        srst <= 1'b0;
        rdc(OFS_LATCH, 8'h00);
        rdc(OFS_DIRECTION, 8'h3F);
        rdc(OFS_ANALOG, 8'h17);
        rdc(OFS_STEERING, 8'h00);
        rdc(OFS_PIN_DATA, 8'h28);
        chk({26'h0, pad.oe_n}, 32'h3F);
        $display("test reset done");
        wr(OFS_STEERING, 32'hFF);
        chk({30'h0, bresp}, {30'h0, RESP_OKAY});
        rdc(OFS_STEERING, 8'h3B);
        rdc(OFS_DIRECTION, 8'h3F);
        rd(8'h1C, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h1C, 32'h0);
        chk({30'h0, bresp}, {30'h0, RESP_SLVERR});
        rdc(OFS_STEERING, 8'h3B);
        $display("test steering mask done");
        wr(OFS_ANALOG, 32'h0);
        wr(OFS_DIRECTION, 32'h0);
        rdc(OFS_DIRECTION, 8'h08);
        wr(OFS_PIN_DATA, 32'h15);
        rdc(OFS_LATCH, 8'h15);
        chk({20'h0, pad.oe_n, pad.out}, 32'h215);
        rdc(OFS_PIN_DATA, 8'h1D);
        wr(OFS_LATCH, 32'hFF);
        rdc(OFS_LATCH, 8'h37);
        wr(OFS_DIRECTION, 32'h3F);
        ext_lvl <= 6'h09;
        repeat (5) @(posedge core_clk);
        rdc(OFS_PIN_DATA, 8'h09);
        rdc(OFS_LATCH, 8'h37);
        $display("test latch done");
        wr(OFS_DIRECTION, 32'h0);
        wr(OFS_ANALOG, 32'h17);
        repeat (5) @(posedge core_clk);
        rdc(OFS_PIN_DATA, 8'h28);
        chk({26'h0, pad.oe_n}, 32'h08);
        wr(OFS_BIT_MODIFY, 32'h0F00);
        rdc(OFS_LATCH, 8'h20);
        wr(OFS_ANALOG, 32'h0);
        repeat (5) @(posedge core_clk);
        wr(OFS_BIT_MODIFY, 32'h0301);
        rdc(OFS_LATCH, 8'h21);
        $display("test analog done");
        wr(OFS_DIRECTION, 32'h3F);
        ext_lvl <= 6'h00;
        pin_c3_in <= 1'b1;
        so_d <= 2'b11;
        osc_d <= 2'b11;
        lc_d <= 2'b11;
        for (int k = 0; k < 3; k++) begin
            wr(OFS_STEERING, {24'h0, st_v[k]});
            repeat (5) @(posedge core_clk);
            chk({26'h0, pad.oe_n}, {26'h0, st_oe[k]});
            chk({26'h0, c_ovr}, {26'h0, st_ovr[k]});
            chk({30'h0, tg_in, ss_in}, {30'h0, st_in[k]});
            rdc(OFS_PIN_DATA, st_pin[k]);
        end
        rdc(OFS_DIRECTION, 8'h3F);
        $display("test pin steering done");
        test_done();
    end
endmodule

bind gps_port gps_port_chk i_gps_port_chk (.core_clk, .srst, .s_axil_awvalid,
    .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
    .s_axil_bready, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rvalid,
    .s_axil_rready, .port_a_pad, .serial_out_drive, .numeric_osc_output,
    .logic_cell_one_output, .port_c_ovr);
